// ==== include/ssr_defs.vh ====
// Purpose: constants for the shift-and-store bus register
// Assumes: included by rtl files only
// Notes: definitions only
`ifndef SSR_DEFS_VH
`define SSR_DEFS_VH
`define SSR_STAGES 8
`define SSR_SYNC_ZERO 2'h0
`define SSR_STAGE_ZERO 8'h00
`define SSR_CASCADE_TAP 7
`define SSR_PIN_COUNT 4
`define SSR_PIN_LINKCLK 0
`define SSR_PIN_SERIAL 1
`define SSR_PIN_STROBE 2
`define SSR_PIN_ENABLE 3
`endif

// ==== rtl/ssr_sync.v ====
// Purpose: two-flop synchroniser for pin inputs
// Assumes: one clock, synchronous active-high reset
// Notes: first flop feeds only the second
`timescale 1ns/100ps
module ssr_sync #(
   parameter WIDTH = 1
) (
   // Clock and reset
   input wire clk_sys,
   input wire rst,
   // Asynchronous input and its synchronised copy
   input wire [WIDTH-1:0] asyncIn,
   output reg [WIDTH-1:0] syncOut
);
   reg [WIDTH-1:0] meta_r;

   always @(posedge clk_sys) begin
      if (rst) begin
         meta_r <= {WIDTH{1'b0}};
         syncOut <= {WIDTH{1'b0}};
      end else begin
         meta_r <= asyncIn;
         syncOut <= meta_r;
      end
   end
endmodule

// ==== rtl/ssr_shift_store.v ====
// Purpose: 8-stage serial shift register with storage latches and tri-state outputs
// Assumes: link clock, data, strobe, enable are pins sampled by clk_sys (10 MHz)
// Notes: link clock edges are found after two-flop synchronisation
// Notes on behaviour
// - Eight stages, eight latches, eight bus outputs
// - Rising link edge shifts data in
// - Strobe high: latches follow; low: hold
// - Enable high drives outputs, low floats them
// - Rising edge: stage seven to eight and cascade
// - Second cascade output updates on falling edge
// - Cascade outputs feed next device data input
`timescale 1ns/100ps
`include "ssr_defs.vh"
module ssr_shift_store #(
   parameter STAGES = `SSR_STAGES
) (
   // Clock and reset
   input wire clk_sys,
   input wire rst,
   // Host side pins
   input wire linkClk,
   input wire serialIn,
   input wire strobe,
   input wire outEnable,
   // Parallel bus outputs
   output reg [STAGES-1:0] parOut,
   output wire [STAGES-1:0] parOutEn,
   // Cascade outputs
   output reg serial_cascade_out,
   output reg serialCascadeLate
);
   // Reset values and the cascade tap position
   localparam [STAGES-1:0] STAGE_RESET = {STAGES{1'b0}};
   localparam BIT_RESET = 1'b0;
   localparam TAP_IDX = `SSR_CASCADE_TAP - 1;
   // The pins have no reset of their own; rst only gives a known start,
   // so a host must clock in a full word before trusting the bus.
   // Every pin lags by the same sync delay, which keeps data and clock aligned

   // Synchronised pin copies
   wire [`SSR_PIN_COUNT-1:0] pinSync;
   wire linkClkSync;
   wire serialInSync;
   wire strobeSync;
   wire outEnableSync;

   // Link clock edge detection
   reg linkClkPrev_r;
   wire riseEdge;
   wire fallEdge;

   // Per-stage values gathered into vectors
   wire [STAGES-1:0] stageQ;
   wire [STAGES-1:0] latchNxt;

   // Output side next values
   reg [STAGES-1:0] parOut_nxt;
   reg cascade_nxt;
   reg cascadeLate_nxt;
   reg enable_r;
   reg enable_nxt;

   genvar gi;

   // Every pin crosses into clk_sys through two flops; the pins share one lag
   ssr_sync #(.WIDTH(`SSR_PIN_COUNT)) uSync (
      .clk_sys(clk_sys),
      .rst(rst),
      .asyncIn({outEnable, strobe, serialIn, linkClk}),
      .syncOut(pinSync)
   );

   assign linkClkSync = pinSync[`SSR_PIN_LINKCLK];
   assign serialInSync = pinSync[`SSR_PIN_SERIAL];
   assign strobeSync = pinSync[`SSR_PIN_STROBE];
   assign outEnableSync = pinSync[`SSR_PIN_ENABLE];

   // Previous level resets to the idle low of the pin, so no false edge follows reset
   always @(posedge clk_sys) begin
      if (rst) begin
         linkClkPrev_r <= BIT_RESET;
      end else begin
         linkClkPrev_r <= linkClkSync;
      end
   end

   // Pulses shorter than one clk_sys period may be missed
   assign riseEdge = linkClkSync & ~linkClkPrev_r;
   assign fallEdge = ~linkClkSync & linkClkPrev_r;

   // One shift flop and one storage flop per stage; stage 0 takes the serial pin
   generate
      for (gi = 0; gi < STAGES; gi = gi + 1) begin : gStage
         reg stageBit_r;
         reg stageBit_nxt;
         reg latchBit_r;
         reg latchBit_nxt;
         wire stageFeed;

         if (gi == 0) begin : gHead
            assign stageFeed = serialInSync;
         end else begin : gBody
            assign stageFeed = stageQ[gi-1];
         end

         always @* begin
            case (riseEdge)
               1'b1: begin
                  stageBit_nxt = stageFeed;
               end
               default: begin
                  stageBit_nxt = stageBit_r;
               end
            endcase
         end

         always @(posedge clk_sys) begin
            if (rst) begin
               stageBit_r <= BIT_RESET;
            end else begin
               stageBit_r <= stageBit_nxt;
            end
         end

         // The latch follows the post-shift value, so a held strobe
         // shows a new bit in the same cycle as the stage takes it
         always @* begin
            case (strobeSync)
               1'b1: begin
                  latchBit_nxt = stageBit_nxt;
               end
               default: begin
                  latchBit_nxt = latchBit_r;
               end
            endcase
         end

         always @(posedge clk_sys) begin
            if (rst) begin
               latchBit_r <= BIT_RESET;
            end else begin
               latchBit_r <= latchBit_nxt;
            end
         end

         assign stageQ[gi] = stageBit_r;
         assign latchNxt[gi] = latchBit_nxt;
      end
   endgenerate

   // Cascade taps the seventh stage before the shift, which is the new eighth stage
   always @* begin
      case (riseEdge)
         1'b1: begin
            cascade_nxt = stageQ[TAP_IDX];
         end
         default: begin
            cascade_nxt = serial_cascade_out;
         end
      endcase
   end

   // Neither strobe nor enable gates the cascade path
   always @(posedge clk_sys) begin
      if (rst) begin
         serial_cascade_out <= BIT_RESET;
      end else begin
         serial_cascade_out <= cascade_nxt;
      end
   end

   // Late copy gives slow-edge neighbours half a link period of hold time
   always @* begin
      case (fallEdge)
         1'b1: begin
            cascadeLate_nxt = serial_cascade_out;
         end
         default: begin
            cascadeLate_nxt = serialCascadeLate;
         end
      endcase
   end

   always @(posedge clk_sys) begin
      if (rst) begin
         serialCascadeLate <= BIT_RESET;
      end else begin
         serialCascadeLate <= cascadeLate_nxt;
      end
   end

   // Parallel data come from a flop fed by the latches' next value
   always @* begin
      parOut_nxt = latchNxt;
   end

   always @(posedge clk_sys) begin
      if (rst) begin
         parOut <= STAGE_RESET;
      end else begin
         parOut <= parOut_nxt;
      end
   end

   // Enable is registered so the bus turns on and off on a clock edge
   always @* begin
      enable_nxt = outEnableSync;
   end

   always @(posedge clk_sys) begin
      if (rst) begin
         enable_r <= BIT_RESET;
      end else begin
         enable_r <= enable_nxt;
      end
   end

   // Enable drives every bit; low leaves the bus floating
   assign parOutEn = {STAGES{enable_r}};
endmodule

// ==== bench/ssr_host.sv ====
// Purpose: host model; Assumes: 800 ns link clock; Notes: first bit sent lands in stage 8
`timescale 1ns/100ps
module ssr_host(output logic linkClk, output logic serialIn);
   initial begin linkClk=0; serialIn=0; end
   task automatic sendByte(input logic [7:0] b);
      for (int i=7; i>=0; i--) begin
         serialIn=b[i];
         #400 linkClk=1;
         #400 linkClk=0;
      end
   endtask
endmodule

// ==== bench/ssr_chk_assertions.sv ====
// Purpose: port checks; Assumes: clk_sys domain; Notes: five cycles covers pin sync lag
`timescale 1ns/100ps
module ssr_chk #(parameter STAGES=8) (input wire clk_sys, input wire rst, input wire linkClk,
   input wire outEnable, input wire [STAGES-1:0] parOutEn, input wire serial_cascade_out,
   input wire serialCascadeLate);
   property p_off; @(posedge clk_sys) disable iff (rst) !outEnable[*5] |-> parOutEn==0; endproperty
   a_off: assert property (p_off) else $error("bus not floated");
   property p_on; @(posedge clk_sys) disable iff (rst) outEnable[*5] |-> &parOutEn; endproperty
   a_on: assert property (p_on) else $error("bus not driven");
   property p_late; @(posedge clk_sys) disable iff (rst)
      $changed(serialCascadeLate) |-> serialCascadeLate==serial_cascade_out; endproperty
   a_late: assert property (p_late) else $error("late cascade differs");
   property p_rise; @(posedge clk_sys) disable iff (rst)
      $changed(serial_cascade_out) |-> $past(linkClk,3) && !$past(linkClk,4); endproperty
   a_rise: assert property (p_rise) else $error("cascade moved off a rising edge");
   property p_fall; @(posedge clk_sys) disable iff (rst)
      $changed(serialCascadeLate) |-> !$past(linkClk,3) && $past(linkClk,4); endproperty
   a_fall: assert property (p_fall) else $error("late cascade moved off a falling edge");
   property p_even; @(posedge clk_sys) disable iff (rst) parOutEn==0 || &parOutEn; endproperty
   a_even: assert property (p_even) else $error("bus enables differ");
endmodule
bind ssr_shift_store ssr_chk #(.STAGES(STAGES)) u_chk(.clk_sys(clk_sys), .rst(rst),
   .linkClk(linkClk),
   .outEnable(outEnable), .parOutEn(parOutEn), .serial_cascade_out(serial_cascade_out),
   .serialCascadeLate(serialCascadeLate));

// ==== bench/ssr_shift_store_tb.sv ====
// Purpose: bench; Assumes: 10 MHz clk_sys; Notes: waits cover sync lag
`timescale 1ns/100ps
module ssr_shift_store_tb;
   logic clk_sys=0, rst=1, strobe=0, outEnable=0;
   wire linkClk, serialIn, sco, scl;
   wire [7:0] parOut, parOutEn;
   int num_errors=0, checked=0, cyc=0;
   always #50 clk_sys=~clk_sys;
   always @(posedge clk_sys) if (++cyc>3000) begin num_errors++; wrap_up(); end
   ssr_host host(.linkClk(linkClk), .serialIn(serialIn));
   ssr_shift_store dut(.clk_sys(clk_sys), .rst(rst), .linkClk(linkClk), .serialIn(serialIn),
      .strobe(strobe), .outEnable(outEnable), .parOut(parOut), .parOutEn(parOutEn),
      .serial_cascade_out(sco), .serialCascadeLate(scl));
   task cmp(input string n, input logic [7:0] e, input logic [7:0] s);
      checked++;
      if (s!==e) begin num_errors++; $display("BAD %s exp %h got %h", n, e, s); end
   endtask
   task wrap_up;
      $display("checked %0d num_errors %0d", checked, num_errors);
      if (num_errors==0 && checked>0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task test_shift;
      strobe=1;
      outEnable=1;
      host.sendByte(8'hA5);
      #800 cmp("par", 8'hA5, parOut);
      cmp("oe", 8'hFF, parOutEn);
      cmp("late", 8'h01, {7'h00, scl});
      cmp("cas1", 8'h01, {7'h00, sco});
      $display("shift test done");
   endtask
   task test_hold;
      @(negedge clk_sys) strobe=0;
      outEnable=0;
      host.sendByte(8'h3C);
      #800 cmp("hold", 8'hA5, parOut);
      cmp("off", 8'h00, parOutEn);
      cmp("cas", 8'h00, {7'h00, sco});
      $display("hold test done");
   endtask
   initial begin
      repeat (20) @(negedge clk_sys);
      rst=0;
      test_shift();
      test_hold();
      wrap_up();
   end
endmodule
